//--- rtl/dtg_host.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Space activates to different banks
// - One clock after write before read
// - 75 ns after self-refresh exit, non-read
// - 200 cycles after self-refresh exit, read
// - Schedule refresh at average interval
// - Never exceed worst-case refresh gap
// - At most eight refreshes postponed or ahead
// - Clock enable high during refresh period
// - One strobe per byte lane
// - Strobe driven with the write command, at the lane's wr_strobe_lane level
// - Wait refresh cycle time after refresh
module dtg_host import dtg_pkg::*; #(
  parameter int LANES = 8,
  parameter bit FAST_GRADE = 1'b0,
  parameter bit SMALL_MODULE = 1'b0,
  parameter int REFI_CYC = SMALL_MODULE ? REFI_SMALL_CYC : REFI_LARGE_CYC,
  parameter int REFC_CYC = SMALL_MODULE ? REFC_SMALL_CYC : REFC_LARGE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire dtg_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic wr_last,
  input wire logic [LANES-1:0] wr_strobe_lane,
  input wire logic [LANES-1:0] strobe_in,
  output dtg_mem_cmd_t mem_cmd,
  output logic [LANES-1:0] strobe_out,
  output logic [LANES-1:0] strobe_oe_n,
  output logic [LANES-1:0] strobe_sync,
  output logic refresh_due,
  output logic [3:0] refresh_debt
);
  localparam logic [CNT_W-1:0] ACT_GAP =
    CNT_W'(FAST_GRADE ? ACT_GAP_FAST_CYC : ACT_GAP_SLOW_CYC);
  localparam logic [CNT_W-1:0] RFC_GAP =
    CNT_W'(FAST_GRADE ? RFC_FAST_CYC : RFC_SLOW_CYC);
  localparam logic [CNT_W-1:0] XSNR_GAP = CNT_W'(XSNR_CYC);
  localparam logic [CNT_W-1:0] XSRD_GAP = CNT_W'(XSRD_CYC);
  localparam logic [CNT_W-1:0] WTR_GAP = CNT_W'(WTR_CYC);
  localparam int RW = $clog2(REFC_CYC + 1);
  localparam logic [RW-1:0] REFI_V = RW'(REFI_CYC - 1);

  typedef enum logic [1:0] {DTG_ACTIVE, DTG_SELFREF} dtg_state_t;

  dtg_state_t state_r, state_nxt;
  logic [1:0] last_bank_r, last_bank_nxt;
  logic act_seen_r, act_seen_nxt;
  logic [RW-1:0] refi_cnt_r, refi_cnt_nxt;
  logic [RW-1:0] gap_cnt_r, gap_cnt_nxt;
  logic [3:0] debt_r, debt_nxt;
  logic [3:0] ahead_r, ahead_nxt;
  dtg_mem_cmd_t cmd_r, cmd_nxt;
  logic wr_drive_r, wr_drive_nxt;
  logic act_ok, rfc_ok, xsnr_ok, xsrd_ok, wtr_ok, allowed, issue;
  logic is_act, is_ref, is_read, is_sref_exit;
  logic [LANES-1:0] strobe_meta_r, strobe_sync_r;

  assign is_act = (req.cmd == DTG_ACT);
  assign is_ref = (req.cmd == DTG_REF);
  assign is_read = (req.cmd == DTG_READ);
  assign is_sref_exit = (req.cmd == DTG_SREF_EXIT);

  // Spacing timers, loaded on the command that starts the limit; the write-to-read timer loads on wr_last
  dtg_gap_timer u_act (.clk(clk), .nrst(nrst), .load(issue && is_act),
    .value(ACT_GAP), .expired(act_ok));
  dtg_gap_timer u_rfc (.clk(clk), .nrst(nrst), .load(issue && is_ref),
    .value(RFC_GAP), .expired(rfc_ok));
  dtg_gap_timer u_xsnr (.clk(clk), .nrst(nrst), .load(issue && is_sref_exit),
    .value(XSNR_GAP), .expired(xsnr_ok));
  dtg_gap_timer u_xsrd (.clk(clk), .nrst(nrst), .load(issue && is_sref_exit),
    .value(XSRD_GAP), .expired(xsrd_ok));
  dtg_gap_timer u_wtr (.clk(clk), .nrst(nrst), .load(wr_last),
    .value(WTR_GAP), .expired(wtr_ok));

  // Admission: every command waits for the timers that guard it
  always_comb begin
    allowed = rfc_ok;
    if (is_read) begin
      allowed = allowed && xsrd_ok && wtr_ok && !wr_last;
    end else if (req.cmd != DTG_NOP) begin
      allowed = allowed && xsnr_ok;
    end
    // Same-bank activate spacing is other timing, not guarded here
    if (is_act && act_seen_r && req.bank != last_bank_r) begin
      allowed = allowed && act_ok;
    end
    if (state_r == DTG_SELFREF) begin
      allowed = allowed && (is_sref_exit || req.cmd == DTG_NOP);
    end else if (is_sref_exit) begin
      allowed = 1'b0;
    end
    // Forced refresh debt: only refresh or precharge may pass
    if (debt_r >= 4'(MAX_POSTPONE) && !is_ref && req.cmd != DTG_PRE) begin
      allowed = 1'b0;
    end
    if (is_ref && ahead_r >= 4'(MAX_POSTPONE)) begin
      allowed = 1'b0;
    end
  end

  assign req_ready = allowed;
  assign issue = req_valid && allowed;

  // Command state: bank tracking, self-refresh mode, output register
  always_comb begin
    state_nxt = state_r;
    last_bank_nxt = last_bank_r;
    act_seen_nxt = act_seen_r;
    cmd_nxt = '{cke: (state_r != DTG_SELFREF), cmd: DTG_NOP, bank: 2'h0};
    if (!rfc_ok) begin
      cmd_nxt.cke = 1'b1;
    end
    if (issue) begin
      cmd_nxt.cmd = req.cmd;
      cmd_nxt.bank = req.bank;
      if (is_act) begin
        last_bank_nxt = req.bank;
        act_seen_nxt = 1'b1;
      end
      unique case (state_r)
        DTG_ACTIVE: begin
          if (req.cmd == DTG_SREF_ENTER) begin
            state_nxt = DTG_SELFREF;
            cmd_nxt.cke = 1'b0;
          end
        end
        DTG_SELFREF: begin
          if (is_sref_exit) begin
            state_nxt = DTG_ACTIVE;
            cmd_nxt.cke = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= DTG_ACTIVE;
      last_bank_r <= 2'h0;
      act_seen_r <= 1'b0;
      cmd_r <= '{cke: 1'b0, cmd: DTG_NOP, bank: 2'h0};
    end else begin
      state_r <= state_nxt;
      last_bank_r <= last_bank_nxt;
      act_seen_r <= act_seen_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // Refresh bookkeeping; self refresh keeps rows alive so the debt pauses
  always_comb begin
    refi_cnt_nxt = refi_cnt_r;
    gap_cnt_nxt = gap_cnt_r;
    debt_nxt = debt_r;
    ahead_nxt = ahead_r;
    if (state_r == DTG_ACTIVE) begin
      refi_cnt_nxt = (refi_cnt_r == REFI_V) ? '0 : refi_cnt_r + 1'b1;
      gap_cnt_nxt = gap_cnt_r + 1'b1;
      if (refi_cnt_r == REFI_V) begin
        if (ahead_r != 4'h0) begin
          ahead_nxt = ahead_r - 1'b1;
        end else begin
          debt_nxt = debt_r + 1'b1;
        end
      end
    end
    // A refresh cancels one owed interval, else counts as early
    if (issue && is_ref) begin
      gap_cnt_nxt = '0;
      if (refi_cnt_r == REFI_V && ahead_r == 4'h0) begin
        debt_nxt = debt_r;
      end else if (debt_r != 4'h0) begin
        debt_nxt = debt_r - 1'b1;
      end else begin
        ahead_nxt = ahead_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refi_cnt_r <= '0;
      gap_cnt_r <= '0;
      debt_r <= DEBT_RST;
      ahead_r <= DEBT_RST;
    end else begin
      refi_cnt_r <= refi_cnt_nxt;
      gap_cnt_r <= gap_cnt_nxt;
      debt_r <= debt_nxt;
      ahead_r <= ahead_nxt;
    end
  end

  // Urgent when any debt is owed or the worst-case gap draws near
  assign refresh_due = (debt_r != 4'h0) ||
    (gap_cnt_r >= RW'(REFC_CYC - REFI_CYC));
  assign refresh_debt = debt_r;

  // Strobes: driven from the write command until wr_last, each lane at its wr_strobe_lane level
  always_comb begin
    wr_drive_nxt = wr_drive_r;
    if (issue && req.cmd == DTG_WRITE) begin
      wr_drive_nxt = 1'b1;
    end else if (wr_last) begin
      wr_drive_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_drive_r <= 1'b0;
    end else begin
      wr_drive_r <= wr_drive_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      // Each lane owns its strobe; no lane looks at another's
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          strobe_meta_r[g] <= 1'b0;
          strobe_sync_r[g] <= 1'b0;
          strobe_out[g] <= 1'b0;
          strobe_oe_n[g] <= 1'b1;
        end else begin
          strobe_meta_r[g] <= strobe_in[g];
          strobe_sync_r[g] <= strobe_meta_r[g];
          strobe_out[g] <= wr_drive_nxt && wr_strobe_lane[g];
          strobe_oe_n[g] <= !wr_drive_nxt;
        end
      end
    end
  endgenerate

  assign strobe_sync = strobe_sync_r;
  assign mem_cmd = cmd_r;

  // Helper: cycles since last refresh command left the block
  logic [CNT_W-1:0] since_ref_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_ref_r <= '1;
    end else if (cmd_r.cmd == DTG_REF) begin
      since_ref_r <= '0;
    end else if (since_ref_r != '1) begin
      since_ref_r <= since_ref_r + 1'b1;
    end
  end

  // Helper: cycles since the self-refresh exit left the block, saturating
  logic [CNT_W-1:0] since_exit_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_exit_r <= '1;
    end else if (cmd_r.cmd == DTG_SREF_EXIT) begin
      since_exit_r <= '0;
    end else if (since_exit_r != '1) begin
      since_exit_r <= since_exit_r + 1'b1;
    end
  end

  sequence s_sref_exit;
    cmd_r.cmd == DTG_SREF_EXIT;
  endsequence

  a_rfc_spacing: assert property (@(posedge clk) disable iff (!nrst)
    (cmd_r.cmd != DTG_NOP && since_ref_r != '1 && cmd_r.cmd != DTG_REF)
      |-> since_ref_r >= RFC_GAP)
    else $error("command issued inside refresh cycle time");
  a_rfc_cke_high: assert property (@(posedge clk) disable iff (!nrst)
    (cmd_r.cmd == DTG_REF) |=> cmd_r.cke [*2])
    else $error("clock enable dropped during refresh");
  a_xsrd_read: assert property (@(posedge clk) disable iff (!nrst)
    (cmd_r.cmd == DTG_READ) |-> since_exit_r >= XSRD_GAP - 12'h001)
    else $error("read too soon after self-refresh exit");
  a_xsnr_cmd: assert property (@(posedge clk) disable iff (!nrst)
    s_sref_exit |=> (cmd_r.cmd == DTG_NOP || cmd_r.cmd == DTG_READ) [*1])
    else $error("command too soon after self-refresh exit");
  a_wtr_block: assert property (@(posedge clk) disable iff (!nrst)
    wr_last |-> !(issue && is_read))
    else $error("read admitted during write turnaround");
  a_post_limit: assert property (@(posedge clk) disable iff (!nrst)
    debt_r <= 4'(MAX_POSTPONE) + 4'h1 && ahead_r <= 4'(MAX_POSTPONE))
    else $error("refresh postponed or advanced too far");
  a_act_other_bank: assert property (@(posedge clk) disable iff (!nrst)
    (issue && is_act) ##1 (issue && is_act && req.bank != last_bank_r)
      |-> 1'b0)
    else $error("activates to different banks too close");
  a_strobe_low: assert property (@(posedge clk) disable iff (!nrst)
    (issue && req.cmd == DTG_WRITE) |=> !strobe_oe_n[0])
    else $error("strobe not driven after write command");
endmodule
`default_nettype wire

//--- rtl/dtg_pkg.sv
package dtg_pkg;
  // Command clock period in picoseconds (20 MHz)
  localparam int CLK_PERIOD_PS = 50000;
  // Spacing limits as printed, in ns
  localparam int ACT_GAP_FAST_NS = 12;
  localparam int ACT_GAP_SLOW_NS = 15;
  localparam int XSNR_NS = 75;
  localparam int RFC_FAST_NS = 72;
  localparam int RFC_SLOW_NS = 75;
  // Cycle counts, least times rounded up
  localparam int ACT_GAP_FAST_CYC = (ACT_GAP_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACT_GAP_SLOW_CYC = (ACT_GAP_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int XSNR_CYC = (XSNR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFC_FAST_CYC = (RFC_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFC_SLOW_CYC = (RFC_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WTR_CYC = 1;
  localparam int XSRD_CYC = 200;
  // Refresh intervals in ns (average and worst-case gap)
  localparam int REFI_SMALL_NS = 15625;
  localparam int REFI_LARGE_NS = 7812;
  localparam int REFC_SMALL_NS = 140600;
  localparam int REFC_LARGE_NS = 70300;
  // Longest times round down
  localparam int REFI_SMALL_CYC = REFI_SMALL_NS * 1000 / CLK_PERIOD_PS;
  localparam int REFI_LARGE_CYC = REFI_LARGE_NS * 1000 / CLK_PERIOD_PS;
  localparam int REFC_SMALL_CYC = REFC_SMALL_NS * 1000 / CLK_PERIOD_PS;
  localparam int REFC_LARGE_CYC = REFC_LARGE_NS * 1000 / CLK_PERIOD_PS;
  localparam int MAX_POSTPONE = 8;
  localparam int CNT_W = 12;
  localparam logic [3:0] DEBT_RST = 4'h0;

  typedef enum logic [2:0] {
    DTG_NOP, DTG_ACT, DTG_READ, DTG_WRITE, DTG_REF, DTG_SREF_ENTER, DTG_SREF_EXIT, DTG_PRE
  } dtg_cmd_t;

  typedef struct packed {
    dtg_cmd_t cmd;
    logic [1:0] bank;
  } dtg_req_t;

  typedef struct packed {
    logic cke;
    dtg_cmd_t cmd;
    logic [1:0] bank;
  } dtg_mem_cmd_t;
endpackage

//--- rtl/dtg_gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter: load a spacing, report when it has run out
module dtg_gap_timer import dtg_pkg::*; #(
  parameter int W = CNT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic expired
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Load wins over the running count
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = value;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign expired = (cnt_r == '0);
endmodule
`default_nettype wire

//--- tb/dtg_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory side: judges command spacing, answers with a lane strobe
module dtg_mem_model import dtg_pkg::*; #(
  parameter int LANES = 2,
  parameter int REFC_CYC = 400
) (
  input wire logic clk,
  input wire logic nrst,
  input wire dtg_mem_cmd_t mem_cmd,
  input wire logic [LANES-1:0] strobe_oe_n,
  output logic [LANES-1:0] strobe_drv,
  output logic bad
);
  int s_act;
  int s_ref;
  int s_exit;
  logic [1:0] act_bank;
  logic tog = 1'b0;
  // Strobe never rests, so a stale or unknown level cannot pass for data
  always @(posedge clk) begin
    tog <= ~tog;
    for (int i = 0; i < LANES; i++) begin
      strobe_drv[i] <= tog ^ i[0];
    end
  end
  // Edges since the last activate, refresh and self-refresh exit; a breach sets a sticky flag
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_act = 99;
      s_ref = 8;
      s_exit = 999;
      act_bank = 2'h0;
      bad = 1'b0;
    end else begin
      s_act++;
      s_ref++;
      s_exit++;
      if (mem_cmd.cmd == DTG_ACT && mem_cmd.bank != act_bank && s_act < ACT_GAP_SLOW_CYC)
        bad = 1'b1;
      if (s_ref < RFC_SLOW_CYC && !mem_cmd.cke) bad = 1'b1;
      if (mem_cmd.cmd != DTG_NOP && s_ref < RFC_SLOW_CYC) bad = 1'b1;
      if (s_ref > REFC_CYC) bad = 1'b1;
      if (mem_cmd.cmd == DTG_READ && s_exit < XSRD_CYC) bad = 1'b1;
      if (!(mem_cmd.cmd inside {DTG_NOP, DTG_READ}) && s_exit < XSNR_CYC) bad = 1'b1;
      if (mem_cmd.cmd == DTG_WRITE && strobe_oe_n != '0) bad = 1'b1;
      if (mem_cmd.cmd == DTG_ACT) begin
        s_act = 0;
        act_bank = mem_cmd.bank;
      end
      if (mem_cmd.cmd == DTG_REF) s_ref = 0;
      if (mem_cmd.cmd == DTG_SREF_EXIT) s_exit = 0;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_ddr_command_timing_guard.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_command_timing_guard import dtg_pkg::*; ();
  localparam int LN = 2;
  localparam int REFI = 40;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  dtg_req_t req = '0;
  logic req_valid = 1'b0;
  logic wr_last = 1'b0;
  logic [LN-1:0] wr_lane = '0;
  logic req_ready;
  logic refresh_due;
  logic [3:0] refresh_debt;
  logic bad;
  logic [LN-1:0] s_out, s_oe_n, s_sync, s_drv, s_pin;
  dtg_mem_cmd_t mem_cmd;
  int n_errors = 0;
  int checks_done = 0;
  // Pin level: the host wins while it drives, else the memory side
  assign s_pin = (~s_oe_n & s_out) | (s_oe_n & s_drv);
  always #25 clk = ~clk;
  // Short refresh counts keep the run brief
  dtg_host #(.LANES(LN), .REFI_CYC(REFI), .REFC_CYC(400)) dut (
    .clk(clk), .nrst(nrst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .wr_last(wr_last), .wr_strobe_lane(wr_lane), .strobe_in(s_pin), .mem_cmd(mem_cmd),
    .strobe_out(s_out), .strobe_oe_n(s_oe_n), .strobe_sync(s_sync),
    .refresh_due(refresh_due), .refresh_debt(refresh_debt));
  dtg_mem_model #(.LANES(LN), .REFC_CYC(400)) mem (
    .clk(clk), .nrst(nrst), .mem_cmd(mem_cmd), .strobe_oe_n(s_oe_n),
    .strobe_drv(s_drv), .bad(bad));
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #5;
    end
  endtask
  // Present a request; ready is combinational, so look after it settles
  task automatic ask(input dtg_cmd_t c, input logic [1:0] b, output logic r);
    req = '{cmd: c, bank: b};
    req_valid = 1'b1;
    #1;
    r = req_ready;
  endtask
  task automatic issue(input dtg_cmd_t c, input logic [1:0] b);
    logic r;
    int k;
    k = 0;
    ask(c, b, r);
    while (r !== 1'b1 && k < 300) begin
      tick(1);
      k++;
      ask(c, b, r);
    end
    tick(1);
    req_valid = 1'b0;
    chk("issued", 12'(mem_cmd.cmd), 12'(c));
  endtask
  task automatic pay();
    while (refresh_debt !== 4'h0) issue(DTG_REF, 2'h0);
  endtask
  task automatic t_reset();
    repeat (3) @(posedge clk);
    #5;
    chk("rst_cmd", 12'(mem_cmd), 12'({1'b0, DTG_NOP, 2'h0}));
    chk("rst_oe", 12'(s_oe_n), 12'h003);
    chk("rst_debt", 12'(refresh_debt), 12'h000);
    nrst = 1'b1;
    tick(1);
    chk("cke", 12'(mem_cmd.cke), 12'h001);
  endtask
  task automatic t_act();
    logic r;
    issue(DTG_ACT, 2'h0);
    ask(DTG_ACT, 2'h1, r);
    chk("act_gap", 12'(r), 12'h000);
    tick(1);
    ask(DTG_ACT, 2'h1, r);
    chk("act_ok", 12'(r), 12'h001);
    tick(1);
    req_valid = 1'b0;
    chk("act_b1", 12'(mem_cmd), 12'({1'b1, DTG_ACT, 2'h1}));
  endtask
  task automatic t_write();
    logic r;
    logic [LN-1:0] seen;
    wr_lane = 2'h2;
    issue(DTG_WRITE, 2'h0);
    chk("wr_oe", 12'(s_oe_n), 12'h000);
    chk("wr_lane", 12'(s_out), 12'h002);
    wr_last = 1'b1;
    ask(DTG_READ, 2'h0, r);
    chk("wtr0", 12'(r), 12'h000);
    tick(1);
    wr_last = 1'b0;
    ask(DTG_READ, 2'h0, r);
    chk("wtr1", 12'(r), 12'h000);
    chk("wr_end", 12'(s_oe_n), 12'h003);
    tick(1);
    ask(DTG_READ, 2'h0, r);
    chk("wtr2", 12'(r), 12'h001);
    tick(1);
    req_valid = 1'b0;
    seen = s_pin;
    tick(2);
    chk("rd_sync", 12'(s_sync), 12'(seen));
  endtask
  task automatic t_ref();
    logic r;
    issue(DTG_REF, 2'h0);
    chk("ref_cke", 12'(mem_cmd.cke), 12'h001);
    repeat (2) begin
      ask(DTG_PRE, 2'h0, r);
      chk("rfc", 12'(r), 12'h000);
      tick(1);
    end
    ask(DTG_PRE, 2'h0, r);
    chk("rfc_end", 12'(r), 12'h001);
    req_valid = 1'b0;
  endtask
  task automatic t_sref();
    logic r;
    int n;
    pay();
    issue(DTG_SREF_ENTER, 2'h0);
    ask(DTG_ACT, 2'h0, r);
    chk("sref_act", 12'(r), 12'h000);
    tick(1);
    req_valid = 1'b0;
    chk("sref_cke", 12'(mem_cmd.cke), 12'h000);
    issue(DTG_SREF_EXIT, 2'h0);
    repeat (2) begin
      ask(DTG_PRE, 2'h0, r);
      chk("xsnr", 12'(r), 12'h000);
      tick(1);
    end
    ask(DTG_PRE, 2'h0, r);
    chk("xsnr_end", 12'(r), 12'h001);
    n = 2;
    ask(DTG_READ, 2'h0, r);
    while (r !== 1'b1 && n < 400) begin
      tick(1);
      n++;
      ask(DTG_READ, 2'h0, r);
    end
    chk("xsrd", 12'(n), 12'(XSRD_CYC));
    tick(1);
    req_valid = 1'b0;
  endtask
  task automatic t_debt();
    logic r;
    pay();
    tick(8 * REFI);
    chk("debt_cap", 12'(refresh_debt), 12'(MAX_POSTPONE));
    chk("due", 12'(refresh_due), 12'h001);
    ask(DTG_READ, 2'h0, r);
    chk("debt_blk", 12'(r), 12'h000);
    ask(DTG_REF, 2'h0, r);
    chk("debt_ref", 12'(r), 12'h001);
    req_valid = 1'b0;
    pay();
  endtask
  // Align to a tick so the burst of refreshes ends before the next one
  task automatic t_ahead();
    logic r;
    int n;
    n = 0;
    while (refresh_debt !== 4'h1 && n < 100) begin
      tick(1);
      n++;
    end
    n = 0;
    while (refresh_debt !== 4'h2 && n < 100) begin
      tick(1);
      n++;
    end
    chk("refi", 12'(n), 12'(REFI));
    repeat (10) issue(DTG_REF, 2'h0);
    ask(DTG_REF, 2'h0, r);
    chk("ahead", 12'(r), 12'h000);
    req_valid = 1'b0;
  endtask
  initial begin
    t_reset();
    t_act();
    t_write();
    t_ref();
    t_sref();
    t_debt();
    t_ahead();
    tick(2);
    chk("mem_side", 12'(bad), 12'h000);
    complete_run();
  end
  // Whole run needs under a thousand cycles
  initial begin
    #(3000 * 50);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
